// *** pkg/cpm_defs.svh ***
// Purpose: constants of the configuration pin multiplexer
// Assumes: included by its bare name
// Notes: mode codes are the values read on the three strap pins
`ifndef CPM_DEFS_SVH
`define CPM_DEFS_SVH
`define CPM_MODE_MASTER_PORT 3'h4
`define CPM_MODE_SLAVE_PORT 3'h6
`define CPM_MODE_FLASH 3'h2
`define CPM_MODE_SLAVE_SERIAL 3'h7
`define CPM_STRAP_RESET 3'h7
`define CPM_WIDTH_X8 2'h0
`define CPM_WIDTH_X16 2'h1
`define CPM_WIDTH_X32 2'h2
`define CPM_ADDR_LO_W 16
`define CPM_ADDR_HI_W 13
`endif

// *** pkg/cpm_pkg.sv ***
// Purpose: types of the configuration pin multiplexer
// Assumes: nothing
// Notes: role fields are one flag per pin group role
package cpm_pkg;
    typedef enum logic [1:0] {
        CPM_IDLE = 2'b01,
        CPM_CONFIG = 2'b10
    } cpm_state_e;

    typedef struct packed {
        logic master_port;
        logic slave_port;
        logic flash;
        logic serial;
        logic wide16;
        logic wide32;
        logic ext_clk;
    } cpm_role_s;
endpackage : cpm_pkg

// *** hdl/cpm_mode_decode.sv ***
// Purpose: decode strap mode and bus width into pin roles
// Assumes: width code from the configuration options
// Notes: illegal width code 3 decodes as x16 in every parallel mode
`timescale 1ns/1ps
`include "cpm_defs.svh"
module cpm_mode_decode (
    input wire logic [2:0] mode,
    input wire logic [1:0] width,
    input wire logic ext_clk_opt,
    output cpm_pkg::cpm_role_s role
);
    always_comb begin
        role = '0;
        case (mode)
            `CPM_MODE_MASTER_PORT: begin
                role.master_port = 1'b1; // [RULE7]
                role.wide16 = (width != `CPM_WIDTH_X8);
                role.ext_clk = ext_clk_opt; // [RULE1]
            end
            `CPM_MODE_SLAVE_PORT: begin
                role.slave_port = 1'b1; // [RULE8]
                role.wide16 = (width != `CPM_WIDTH_X8);
                role.wide32 = (width == `CPM_WIDTH_X32);
            end
            `CPM_MODE_FLASH: begin
                role.flash = 1'b1; // [RULE9]
                role.wide16 = (width != `CPM_WIDTH_X8);
                role.ext_clk = ext_clk_opt; // [RULE1]
            end
            `CPM_MODE_SLAVE_SERIAL: begin
                role.serial = 1'b1; // [RULE10]
            end
            default: begin
                role = '0;
            end
        endcase
    end
endmodule : cpm_mode_decode

// *** hdl/cpm_pin_mux.sv ***
// Purpose: assign shared configuration pins their role for the parallel modes
// Assumes: all inputs synchronous to sys_clk; pin oe_n low means driving
// Notes: pin assignment is frozen from cfg_start until cfg_done
//
// Function
// [RULE1] external clock pin used only when the option selects it in master modes
// [RULE2] serial chain output driven only in serial chain or debug image; else hi-Z
// [RULE3] parallel modes: shared pin is downstream enable, driven only in parallel chain
// [RULE4] revision outputs driven only after reboot or enabled fallback event
// [RULE5] user logic should avoid reusing revision pins after configuration
// [RULE6] unassigned pins ignored as inputs and held hi-Z during configuration
// [RULE7] strap 100: master byte port, select and rw inputs, data 0-7 or 0-15
// [RULE8] strap 110: slave byte port, no external clock, x32 data 16-31 on address pins
// [RULE9] strap 010: master flash, drives flash controls and address 0-28
// [RULE10] unconnected strap pins read high, giving default slave serial 111
// [RULE11] slave byte port rejects encrypted images at x16 and x32
// [RULE12] strap latched at configuration start, assignment held until the end
`timescale 1ns/1ps
`include "cpm_defs.svh"
module cpm_pin_mux (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic cfg_start,
    input wire logic cfg_done,
    input wire logic [2:0] mode_strap,
    input wire logic [2:0] mode_strap_driven,
    input wire logic [1:0] width_sel,
    input wire logic external_cfg_clock_option,
    input wire logic debug_image_option,
    input wire logic fallback_option,
    input wire logic fallback_event,
    input wire logic multi_image_reboot,
    input wire logic serial_chain,
    input wire logic parallel_chain,
    input wire logic encrypted_image,
    input wire logic serial_data,
    input wire logic downstream_enable_val,
    input wire logic [1:0] revision_val,
    input wire logic [28:0] core_flash_addr,
    input wire logic core_flash_cs,
    input wire logic core_flash_oe,
    input wire logic core_flash_we,
    input wire logic core_flash_adv,
    input wire logic external_master_clock_in,
    input wire logic port_chip_select_in,
    input wire logic port_read_write_sel,
    input wire logic [15:0] data_pin_in,
    input wire logic [15:0] addr_lo_pin_in,
    output logic [15:0] addr_lo_pin_out,
    output logic [15:0] addr_lo_pin_oe_n,
    output logic [12:0] addr_hi_pin_out,
    output logic addr_hi_pin_oe_n,
    output logic flash_chip_select,
    output logic flash_output_enable,
    output logic flash_write_enable,
    output logic flash_address_valid,
    output logic flash_ctrl_oe_n,
    output logic chain_pin_out,
    output logic chain_pin_oe_n,
    output logic [1:0] revision_select_outputs,
    output logic revision_select_oe_n,
    output logic [31:0] cfg_data,
    output logic cfg_port_select,
    output logic cfg_port_rw,
    output logic ext_clock_in_use,
    output logic ext_clock_sample,
    output logic encrypt_reject,
    output logic [2:0] latched_mode,
    output logic cfg_active
);
    // ------------------------------------------------------------
    // strap sampling and mode decode
    // ------------------------------------------------------------
    cpm_pkg::cpm_state_e state;
    cpm_pkg::cpm_role_s live_role;
    cpm_pkg::cpm_role_s role;
    logic [2:0] strap_eff;
    logic [1:0] width;
    logic rs_pending;
    logic in_cfg;
    logic par;

    assign strap_eff = mode_strap | ~mode_strap_driven; // [RULE10]
    assign in_cfg = (state == cpm_pkg::CPM_CONFIG);
    assign par = role.master_port | role.slave_port | role.flash;

    cpm_mode_decode u_decode (
        .mode(strap_eff),
        .width(width_sel),
        .ext_clk_opt(external_cfg_clock_option),
        .role(live_role)
    );

    // ------------------------------------------------------------
    // configuration cycle
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= cpm_pkg::CPM_IDLE;
        end else begin
            case (state)
                cpm_pkg::CPM_IDLE: begin
                    if (cfg_start) begin
                        state <= cpm_pkg::CPM_CONFIG;
                    end
                end
                cpm_pkg::CPM_CONFIG: begin
                    if (cfg_done) begin
                        state <= cpm_pkg::CPM_IDLE;
                    end
                end
                default: begin
                    state <= cpm_pkg::CPM_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            latched_mode <= `CPM_STRAP_RESET;
            width <= `CPM_WIDTH_X8;
            role <= '0;
        end else if (state == cpm_pkg::CPM_IDLE && cfg_start) begin
            latched_mode <= strap_eff; // [RULE12]
            width <= width_sel;
            role <= live_role;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_active <= 1'b0;
        end else begin
            cfg_active <= in_cfg;
        end
    end

    // ------------------------------------------------------------
    // revision select: set on event, set wins over clear
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rs_pending <= 1'b0;
        end else if (multi_image_reboot || (fallback_option && fallback_event)) begin
            rs_pending <= 1'b1; // [RULE4]
        end else if (cfg_done) begin
            rs_pending <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            revision_select_outputs <= 2'h0;
            revision_select_oe_n <= 1'b1;
        end else begin
            revision_select_outputs <= revision_val;
            revision_select_oe_n <= ~rs_pending; // [RULE4]
        end
    end

    // ------------------------------------------------------------
    // flash address and control pins
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            addr_lo_pin_out <= 16'h0000;
            addr_lo_pin_oe_n <= 16'hffff;
            addr_hi_pin_out <= 13'h0000;
            addr_hi_pin_oe_n <= 1'b1;
            flash_chip_select <= 1'b1;
            flash_output_enable <= 1'b1;
            flash_write_enable <= 1'b1;
            flash_address_valid <= 1'b1;
            flash_ctrl_oe_n <= 1'b1;
        end else begin
            addr_lo_pin_out <= core_flash_addr[15:0];
            addr_hi_pin_out <= core_flash_addr[28:16];
            addr_lo_pin_oe_n <= {16{~(in_cfg && role.flash)}}; // [RULE9] [RULE6]
            addr_hi_pin_oe_n <= ~(in_cfg && role.flash); // [RULE9] [RULE6]
            flash_ctrl_oe_n <= ~(in_cfg && role.flash); // [RULE9] [RULE6]
            flash_chip_select <= core_flash_cs;
            flash_output_enable <= core_flash_oe;
            flash_write_enable <= core_flash_we;
            flash_address_valid <= core_flash_adv;
        end
    end

    // ------------------------------------------------------------
    // shared chain pin
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            chain_pin_out <= 1'b1;
            chain_pin_oe_n <= 1'b1;
        end else if (in_cfg && par) begin
            chain_pin_out <= downstream_enable_val;
            chain_pin_oe_n <= ~parallel_chain; // [RULE3]
        end else begin
            chain_pin_out <= serial_data;
            chain_pin_oe_n <= ~((in_cfg && role.serial && serial_chain) || debug_image_option); // [RULE2]
        end
    end

    // ------------------------------------------------------------
    // inputs toward the configuration core
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_data <= 32'h00000000;
            cfg_port_select <= 1'b1;
            cfg_port_rw <= 1'b1;
            ext_clock_in_use <= 1'b0;
            ext_clock_sample <= 1'b0;
            encrypt_reject <= 1'b0;
        end else begin
            cfg_data[7:0] <= (in_cfg && par) ? data_pin_in[7:0] : 8'h00; // [RULE6]
            cfg_data[15:8] <= (in_cfg && par && role.wide16) ? data_pin_in[15:8] : 8'h00; // [RULE7]
            cfg_data[31:16] <= (in_cfg && role.wide32) ? addr_lo_pin_in : 16'h0000; // [RULE8]
            if (in_cfg && (role.master_port || role.slave_port)) begin
                cfg_port_select <= port_chip_select_in; // [RULE7] [RULE8]
                cfg_port_rw <= port_read_write_sel;
            end else begin
                cfg_port_select <= 1'b1; // [RULE9]
                cfg_port_rw <= 1'b1;
            end
            ext_clock_in_use <= in_cfg && role.ext_clk; // [RULE1]
            ext_clock_sample <= in_cfg && role.ext_clk && external_master_clock_in; // [RULE1]
            encrypt_reject <= in_cfg && role.slave_port && encrypted_image
                && (width != `CPM_WIDTH_X8); // [RULE11]
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_cfg_begin;
        state == cpm_pkg::CPM_IDLE && cfg_start;
    endsequence

    sequence s_rs_event;
        multi_image_reboot || (fallback_option && fallback_event);
    endsequence

    a_strap_latch: assert property (@(posedge sys_clk) disable iff (rst) // [RULE12]
        s_cfg_begin |=> latched_mode == $past(strap_eff))
        else $error("mode not latched at start");

    a_strap_hold: assert property (@(posedge sys_clk) disable iff (rst) // [RULE12]
        in_cfg && !cfg_done |=> $stable(latched_mode) && $stable(role))
        else $error("mode changed during configuration");

    a_rs_drive: assert property (@(posedge sys_clk) disable iff (rst) // [RULE4]
        s_rs_event |=> ##1 !revision_select_oe_n)
        else $error("revision pins not driven after event");

    a_rs_hiz: assert property (@(posedge sys_clk) disable iff (rst) // [RULE4]
        !rs_pending |=> revision_select_oe_n)
        else $error("revision pins driven without event");

    a_flash_pins: assert property (@(posedge sys_clk) disable iff (rst) // [RULE9]
        !flash_ctrl_oe_n |-> $past(in_cfg) && $past(role.flash) && !addr_hi_pin_oe_n)
        else $error("flash pins driven outside flash mode");

    a_chain_hiz: assert property (@(posedge sys_clk) disable iff (rst) // [RULE3]
        in_cfg && par && !parallel_chain |=> chain_pin_oe_n)
        else $error("chain pin driven without parallel chain");

    a_serial_hiz: assert property (@(posedge sys_clk) disable iff (rst) // [RULE2]
        !in_cfg && !debug_image_option |=> chain_pin_oe_n)
        else $error("serial chain pin driven outside its cases");

    a_ext_clk_gate: assert property (@(posedge sys_clk) disable iff (rst) // [RULE1]
        ext_clock_in_use |-> $past(role.ext_clk) && !$past(role.slave_port))
        else $error("external clock used in wrong mode");

    a_encrypt_rej: assert property (@(posedge sys_clk) disable iff (rst) // [RULE11]
        in_cfg && role.slave_port && encrypted_image && width != `CPM_WIDTH_X8
        |=> encrypt_reject)
        else $error("encrypted wide image not rejected");

    a_upper_ignored: assert property (@(posedge sys_clk) disable iff (rst) // [RULE6]
        !role.wide32 |=> cfg_data[31:16] == 16'h0000)
        else $error("unused address pins not ignored");

    a_default_strap: assert property (@(posedge sys_clk) disable iff (rst) // [RULE10]
        s_cfg_begin and (mode_strap_driven == 3'h0) |=> latched_mode == `CPM_STRAP_RESET)
        else $error("floating straps did not read default");
endmodule : cpm_pin_mux

// *** tb/cpm_far_model.sv ***
// Purpose: far side of the pin mux: parallel flash behind the address pins, host otherwise
// Assumes: flash control pins are active low; data answers combinationally to the address
// Notes: released data lines show a toggling pattern, never the last value
`timescale 1ns/1ps
module cpm_far_model (
    input wire logic sys_clk,
    input wire logic [15:0] addr_lo,
    input wire logic flash_chip_select,
    input wire logic flash_output_enable,
    input wire logic flash_ctrl_oe_n,
    input wire logic [15:0] host_data,
    output logic [15:0] data_pins
);
    logic [15:0] last = 16'h0;

    always_ff @(posedge sys_clk) begin
        last <= data_pins;
    end

    // revision pins are left unread here, so nothing reuses them
    always_comb begin
        if (flash_ctrl_oe_n) begin
            data_pins = host_data;
        end else if (!flash_chip_select && !flash_output_enable) begin
            data_pins = addr_lo ^ 16'h5a5a;
        end else begin
            data_pins = ~last;
        end
    end
endmodule : cpm_far_model

// *** tb/config_parallel_mode_pin_mux_tb_top.sv ***
// Purpose: self-checking bench of the configuration pin multiplexer
// Assumes: inputs change at the falling edge; outputs sampled there
// Notes: one configuration cycle per tested mode and width, then revision and debug pin checks
`timescale 1ns/1ps
module config_parallel_mode_pin_mux_tb_top;
    logic sys_clk, rst, cfg_start, cfg_done, ext_opt, dbg_opt, fb_opt, fb_evt, reboot;
    logic s_chain, p_chain, enc, ser_d, ds_val, ck_in, cs_in, rw_in, f_cs, f_oe, f_we, f_adv;
    logic [2:0] strap, strap_drv, lmode;
    logic [1:0] wsel, rev_val, rev;
    logic [28:0] f_addr;
    logic [15:0] host_d, alo_in, d_in, alo_out, alo_oe;
    logic [12:0] ahi_out;
    logic ahi_oe, fcs, foe, fwe, fadv, fctl_oe, ch_out, ch_oe, rev_oe, sel, rw, ckuse, cks, rej;
    logic act;
    logic [31:0] cdat;
    int miscompares = 0;
    int total_checks = 0;
    int cyc = 0;

    cpm_pin_mux dut_u (.sys_clk(sys_clk), .rst(rst), .cfg_start(cfg_start),
        .cfg_done(cfg_done), .mode_strap(strap), .mode_strap_driven(strap_drv),
        .width_sel(wsel), .external_cfg_clock_option(ext_opt), .debug_image_option(dbg_opt),
        .fallback_option(fb_opt), .fallback_event(fb_evt), .multi_image_reboot(reboot),
        .serial_chain(s_chain), .parallel_chain(p_chain), .encrypted_image(enc),
        .serial_data(ser_d), .downstream_enable_val(ds_val), .revision_val(rev_val),
        .core_flash_addr(f_addr), .core_flash_cs(f_cs), .core_flash_oe(f_oe),
        .core_flash_we(f_we), .core_flash_adv(f_adv), .external_master_clock_in(ck_in),
        .port_chip_select_in(cs_in), .port_read_write_sel(rw_in), .data_pin_in(d_in),
        .addr_lo_pin_in(alo_in), .addr_lo_pin_out(alo_out), .addr_lo_pin_oe_n(alo_oe),
        .addr_hi_pin_out(ahi_out), .addr_hi_pin_oe_n(ahi_oe), .flash_chip_select(fcs),
        .flash_output_enable(foe), .flash_write_enable(fwe), .flash_address_valid(fadv),
        .flash_ctrl_oe_n(fctl_oe), .chain_pin_out(ch_out), .chain_pin_oe_n(ch_oe),
        .revision_select_outputs(rev), .revision_select_oe_n(rev_oe), .cfg_data(cdat),
        .cfg_port_select(sel), .cfg_port_rw(rw), .ext_clock_in_use(ckuse),
        .ext_clock_sample(cks), .encrypt_reject(rej), .latched_mode(lmode), .cfg_active(act));

    cpm_far_model far_u (.sys_clk(sys_clk), .addr_lo(alo_out), .flash_chip_select(fcs),
        .flash_output_enable(foe), .flash_ctrl_oe_n(fctl_oe), .host_data(host_d),
        .data_pins(d_in));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            miscompares = miscompares + 1;
            wrap_up();
        end
    end

    // wide enough that no packed group of outputs loses its top bits
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("[ERR] %0t got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task wrap_up();
        if (miscompares == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // strap and start, then wait out the two-cycle pin latency
    task start(input logic [2:0] m, input logic [1:0] w);
        @(negedge sys_clk) strap = m; wsel = w; cfg_start = 1'b1;
        @(negedge sys_clk) cfg_start = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask : start

    task done_cfg();
        @(negedge sys_clk) cfg_done = 1'b1;
        @(negedge sys_clk) cfg_done = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask : done_cfg

    task pulse_rev(input logic r);
        @(negedge sys_clk) reboot = r; fb_evt = ~r;
        @(negedge sys_clk) reboot = 1'b0; fb_evt = 1'b0;
    endtask : pulse_rev

    initial begin
        rst = 1'b1; cfg_start = 0; cfg_done = 0; ext_opt = 0; dbg_opt = 0; fb_opt = 0;
        fb_evt = 0; reboot = 0; s_chain = 0; p_chain = 0; enc = 0; ser_d = 1; ds_val = 0;
        ck_in = 1; cs_in = 0; rw_in = 0; f_cs = 0; f_oe = 0; f_we = 1; f_adv = 0;
        strap = 3'h0; strap_drv = 3'h0; wsel = 2'h0; rev_val = 2'h2;
        f_addr = 29'h1abc1234; host_d = 16'ha5c3; alo_in = 16'h1e2d;
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        chk({alo_oe, ahi_oe, fctl_oe, ch_oe, rev_oe}, 20'hfffff);
        chk({lmode, sel, rw, act}, 6'h3e);
        s_chain = 1'b1;
        start(3'h0, 2'h0);
        chk(lmode, 3'h7);
        chk({ch_oe, ch_out}, 2'h1);
        done_cfg();
        chk(ch_oe, 1'b1);
        s_chain = 1'b0; strap_drv = 3'h7; ext_opt = 1'b1;
        start(3'h4, 2'h1);
        chk(cdat, 32'ha5c3);
        chk({sel, rw, ckuse, cks}, 4'h3);
        chk({alo_oe, ahi_oe, fctl_oe, ch_oe}, 19'h7ffff);
        start(3'h2, 2'h1);
        chk({lmode, fctl_oe, act}, 5'h13);
        done_cfg();
        ext_opt = 1'b0;
        start(3'h4, 2'h0);
        chk({cdat, ckuse}, 33'h186);
        done_cfg();
        ext_opt = 1'b1; enc = 1'b1; p_chain = 1'b1;
        start(3'h6, 2'h2);
        chk(cdat, 32'h1e2da5c3);
        chk({ckuse, rej}, 2'h1);
        chk({ch_oe, ch_out}, 2'h0);
        done_cfg();
        chk(ch_oe, 1'b1);
        start(3'h6, 2'h0);
        chk({rej, cdat}, 33'hc3);
        done_cfg();
        enc = 1'b0; p_chain = 1'b0;
        start(3'h2, 2'h1);
        chk({ahi_out, alo_out}, 29'h1abc1234);
        chk({alo_oe, ahi_oe, fctl_oe}, 18'h0);
        chk({fcs, foe, fwe, fadv, sel, rw, ckuse}, 7'h17);
        repeat (2) @(negedge sys_clk);
        chk(cdat, 32'h1234 ^ 32'h5a5a);
        done_cfg();
        chk({alo_oe[0], ahi_oe, fctl_oe, act}, 4'he);
        pulse_rev(1'b0);
        @(negedge sys_clk);
        chk(rev_oe, 1'b1);
        fb_opt = 1'b1;
        pulse_rev(1'b0);
        chk(rev_oe, 1'b1);
        @(negedge sys_clk);
        chk({rev_oe, rev}, 3'h2);
        start(3'h4, 2'h0);
        done_cfg();
        chk(rev_oe, 1'b1);
        fb_opt = 1'b0; rev_val = 2'h1;
        pulse_rev(1'b1);
        @(negedge sys_clk);
        chk({rev_oe, rev}, 3'h1);
        dbg_opt = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({ch_oe, ch_out}, 2'h1);
        dbg_opt = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk(ch_oe, 1'b1);
        wrap_up();
    end
endmodule : config_parallel_mode_pin_mux_tb_top
